//--- rtl/ciee_pkg.sv
// Function
// RULE1: finish current instruction, then start entry
// RULE2: stack all core registers except index high
// RULE3: load vector of winning source into PC
// RULE4: return pulls flags, registers, return address
// RULE5: take request only when global mask clear
// RULE6: entry sets mask; unstacked flags restore it
// RULE7: reset sets mask; transfer or clear clears
// RULE8: 128 two-byte vectors descending from top
// RULE9: 126 peripheral request inputs, own vectors
// RULE10: request starts processing at instruction boundary
// RULE11: partner arbitrates and encodes winning request; here ciee_prio_enc inside the core does it, the partner only latches
// RULE12: trap outranks all; holds until vector fetched
// RULE13: wait gates core clock; request wakes immediately
// RULE14: stop halts clocks; capable sources wake asynchronously
// RULE15: service winner only; others stay pending
// RULE16: return restores mask on second cycle
// RULE17: partner holds latched request until serviced
// RULE18: stack pointer steps one per byte
package ciee_pkg;

    localparam int          NUM_SRC       = 126;
    localparam int          STACK_BYTES   = 5;
    localparam int          FLAG_MASK_BIT = 3;
    localparam logic [6:0]  CODE_TRAP     = 7'h01;
    localparam logic [6:0]  CODE_REQ0     = 7'h02;
    localparam logic [7:0]  VEC_HI_USER   = 8'hFF;
    localparam logic [7:0]  VEC_HI_MON    = 8'hFE;
    localparam logic [7:0]  VEC_LO_TOP    = 8'hFE;

    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_STAT      = 8'h04;
    localparam logic [7:0]  OFS_MASK      = 8'h08;
    localparam logic [7:0]  OFS_INFO      = 8'h0C;
    localparam int          CTRL_MON_BIT  = 0;
    localparam int          EVT_ENTRY     = 0;
    localparam int          EVT_RETURN    = 1;
    localparam int          EVT_WAKE      = 2;
    localparam int          EVT_W         = 3;

    localparam logic        RST_MASK_I    = 1'b1;
    localparam logic        RST_MON       = 1'b0;
    localparam logic [2:0]  RST_EVT_MASK  = 3'h0;
    localparam logic [15:0] RST_SP        = 16'h00FF;

    typedef enum logic [6:0]
    {
        ST_IDLE = 7'h01,
        ST_PUSH = 7'h02,
        ST_VECH = 7'h04,
        ST_VECL = 7'h08,
        ST_PULL = 7'h10,
        ST_WAIT = 7'h20,
        ST_STOP = 7'h40
    } ciee_state_e;

    typedef struct packed
    {
        logic [7:0]  acc;
        logic [7:0]  idxLo;
        logic [7:0]  flags;
        logic [15:0] pc;
    } ciee_regs_s;

    typedef struct packed
    {
        logic        instrBoundary;
        logic        trapFetched;
        logic        trapReturn;
        logic        maskClear;
        logic        maskSet;
        logic        flagsXfer;
        logic        xferMaskBit;
        logic        waitReq;
        logic        stopReq;
    } ciee_core_ctl_s;

    typedef struct packed
    {
        logic        req;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ciee_mem_s;

    typedef struct packed
    {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ciee_apb_req_s;

    typedef struct packed
    {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ciee_apb_rsp_s;

endpackage

//--- rtl/ciee_prio_enc.sv
`timescale 1ns/1ps
`default_nettype none
module ciee_prio_enc
#(
    parameter int NUM = 126
)
(
    input  wire logic [NUM-1:0] req,
    output logic                any,
    output logic [6:0]          code
);
    import ciee_pkg::*;

    logic [NUM:0]   below;
    logic [NUM-1:0] win;

    assign below[0] = 1'b0;

    // lowest index has highest priority
    genvar i;
    generate
        for (i = 0; i < NUM; i++)
        begin : g_bit
            assign below[i+1] = below[i] | req[i];
            assign win[i]     = req[i] & ~below[i];
        end
    endgenerate

    always_comb
    begin
        code = 7'h00;
        for (int k = 0; k < NUM; k++)
        begin
            if (win[k])
            begin
                code = k[6:0];
            end
        end
    end

    assign any = below[NUM];

endmodule
`default_nettype wire

//--- rtl/ciee_core_intr.sv
`timescale 1ns/1ps
`default_nettype none
module ciee_core_intr
#(
    parameter int                         NUM_REQ     = ciee_pkg::NUM_SRC,
    parameter logic [ciee_pkg::NUM_SRC-1:0] STOP_WAKE = '1
)
(
    input  wire logic                     sys_clk,
    input  wire logic                     rstn,
    input  wire ciee_pkg::ciee_core_ctl_s coreCtl,
    input  wire ciee_pkg::ciee_regs_s     regsIn,
    input  wire logic [15:0]              spIn,
    input  wire logic [NUM_REQ-1:0]       irqReq,
    input  wire logic [7:0]               memRdata,
    input  wire logic                     memAck,
    input  wire ciee_pkg::ciee_apb_req_s  apbReq,
    output var  ciee_pkg::ciee_mem_s      memOut,
    output var  ciee_pkg::ciee_regs_s     regsOut,
    output logic [15:0]                   spOut,
    output logic                          vecLoad,
    output logic                          restoreLoad,
    output logic                          coreHold,
    output logic                          coreClkEn,
    output logic                          sysClkEn,
    output logic                          maskBit,
    output logic                          intAck,
    output logic [6:0]                    ackCode,
    output var  ciee_pkg::ciee_apb_rsp_s  apbRsp,
    output logic                          irqOut
);
    import ciee_pkg::*;

    typedef struct packed
    {
        ciee_state_e          state;
        logic [2:0]           step;
        logic                 iMask;
        logic                 trapPend;
        logic [6:0]           code;
        logic [STACK_BYTES-1:0][7:0] stk;
        logic [15:0]          sp;
        ciee_mem_s            mem;
        ciee_regs_s           regs;
        logic                 vecLoad;
        logic                 restoreLoad;
        logic                 coreHold;
        logic                 coreClkEn;
        logic                 sysClkEn;
        logic                 intAck;
        logic [6:0]           ackCode;
        logic                 mon;
        logic [EVT_W-1:0]     sts;
        logic [EVT_W-1:0]     msk;
        logic                 irqOut;
        ciee_apb_rsp_s        apb;
        logic [NUM_REQ-1:0]   sync1;
        logic [NUM_REQ-1:0]   sync2;
    } ciee_top_st_s;

    ciee_top_st_s st_r;
    ciee_top_st_s st_nxt;

    logic       reqAny;
    logic [6:0] reqCode;
    logic       stopAny;

    ////////////////////////////////////////////////////////////////////////////
    // request arbitration over synchronised lines

    ciee_prio_enc #(.NUM(NUM_REQ)) u_prio
    (
        .req  (st_r.sync2),
        .any  (reqAny),
        .code (reqCode)
    );

    // stop mode: only capable sources may wake the part
    assign stopAny = |(st_r.sync2 & STOP_WAKE);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic [7:0] vecHi;
    logic [7:0] vecLo;
    assign vecHi = st_r.mon ? VEC_HI_MON : VEC_HI_USER;
    assign vecLo = VEC_LO_TOP - {st_r.code, 1'b0}; // see RULE8

    always_comb
    begin
        logic             takeInt;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] clr;
        logic [7:0]       stFlags;
        logic             apbHit;
        takeInt = 1'b0;
        evt     = '0;
        clr     = '0;
        stFlags = regsIn.flags;
        apbHit  = apbReq.psel && apbReq.penable && !st_r.apb.pready;

        st_nxt             = st_r;
        st_nxt.sync1       = irqReq; // see RULE14
        st_nxt.sync2       = st_r.sync1;
        st_nxt.vecLoad     = 1'b0;
        st_nxt.restoreLoad = 1'b0;
        st_nxt.intAck      = 1'b0;
        st_nxt.apb.pready  = 1'b0;
        st_nxt.apb.pslverr = 1'b0;

        if (coreCtl.trapFetched)
        begin
            st_nxt.trapPend = 1'b1;
        end

        // mask instructions only act between interrupt sequences
        if (st_r.state == ST_IDLE)
        begin
            if (coreCtl.maskClear)
            begin
                st_nxt.iMask = 1'b0; // see RULE7
            end
            else if (coreCtl.flagsXfer)
            begin
                st_nxt.iMask = coreCtl.xferMaskBit; // see RULE7
            end
            else if (coreCtl.maskSet)
            begin
                st_nxt.iMask = 1'b1;
            end
        end

        unique case (st_r.state)
            ST_IDLE:
            begin
                // requests only sampled at an instruction boundary
                if (coreCtl.instrBoundary && (st_r.trapPend || (reqAny && !st_r.iMask))) // see RULE1 RULE5 RULE10
                begin
                    takeInt = 1'b1;
                end
                else if (coreCtl.trapReturn)
                begin
                    st_nxt.sp       = spIn;
                    st_nxt.step     = 3'h0;
                    st_nxt.coreHold = 1'b1;
                    st_nxt.state    = ST_PULL;
                end
                else if (coreCtl.stopReq)
                begin
                    st_nxt.coreClkEn = 1'b0;
                    st_nxt.sysClkEn  = 1'b0; // see RULE14
                    st_nxt.state     = ST_STOP;
                end
                else if (coreCtl.waitReq)
                begin
                    st_nxt.coreClkEn = 1'b0; // see RULE13
                    st_nxt.state     = ST_WAIT;
                end
            end
            ST_PUSH:
            begin
                st_nxt.mem.req   = 1'b1;
                st_nxt.mem.wr    = 1'b1;
                st_nxt.mem.addr  = st_r.sp;
                st_nxt.mem.wdata = st_r.stk[st_r.step]; // see RULE2
                if (st_r.mem.req && memAck)
                begin
                    st_nxt.mem.req = 1'b0;
                    st_nxt.sp      = st_r.sp - 16'h0001; // see RULE18
                    st_nxt.step    = st_r.step + 3'h1;
                    if (st_r.step == 3'(STACK_BYTES - 1))
                    begin
                        st_nxt.step  = 3'h0;
                        st_nxt.state = ST_VECH;
                    end
                end
            end
            ST_VECH:
            begin
                st_nxt.mem.req  = 1'b1;
                st_nxt.mem.wr   = 1'b0;
                st_nxt.mem.addr = {vecHi, vecLo};
                if (st_r.mem.req && memAck)
                begin
                    st_nxt.mem.req       = 1'b0;
                    st_nxt.regs.pc[15:8] = memRdata;
                    st_nxt.state         = ST_VECL;
                end
            end
            ST_VECL:
            begin
                st_nxt.mem.req  = 1'b1;
                st_nxt.mem.wr   = 1'b0;
                st_nxt.mem.addr = {vecHi, vecLo + 8'h01};
                if (st_r.mem.req && memAck)
                begin
                    st_nxt.mem.req      = 1'b0;
                    st_nxt.regs.pc[7:0] = memRdata;
                    st_nxt.vecLoad      = 1'b1; // see RULE3
                    st_nxt.coreHold     = 1'b0;
                    st_nxt.state        = ST_IDLE;
                    evt[EVT_ENTRY]      = 1'b1;
                    // trap stays pending until its vector is in
                    if (st_r.code == CODE_TRAP)
                    begin
                        st_nxt.trapPend = 1'b0; // see RULE12
                    end
                end
            end
            ST_PULL:
            begin
                st_nxt.mem.req  = 1'b1;
                st_nxt.mem.wr   = 1'b0;
                st_nxt.mem.addr = st_r.sp + 16'h0001;
                if (st_r.mem.req && memAck)
                begin
                    st_nxt.mem.req = 1'b0;
                    st_nxt.sp      = st_r.sp + 16'h0001; // see RULE18
                    st_nxt.step    = st_r.step + 3'h1;
                    unique case (st_r.step)
                        3'h0:
                        begin
                            st_nxt.regs.flags = memRdata;
                            st_nxt.iMask      = memRdata[FLAG_MASK_BIT]; // see RULE6 RULE16
                        end
                        3'h1:    st_nxt.regs.acc       = memRdata;
                        3'h2:    st_nxt.regs.idxLo     = memRdata;
                        3'h3:    st_nxt.regs.pc[15:8]  = memRdata;
                        default:
                        begin
                            st_nxt.regs.pc[7:0] = memRdata;
                            st_nxt.restoreLoad  = 1'b1; // see RULE4
                            st_nxt.coreHold     = 1'b0;
                            st_nxt.step         = 3'h0;
                            st_nxt.state        = ST_IDLE;
                            evt[EVT_RETURN]     = 1'b1;
                        end
                    endcase
                end
            end
            ST_WAIT:
            begin
                if (reqAny && !st_r.iMask)
                begin
                    takeInt        = 1'b1; // see RULE13
                    evt[EVT_WAKE]  = 1'b1;
                end
            end
            ST_STOP:
            begin
                if (stopAny && !st_r.iMask)
                begin
                    takeInt        = 1'b1; // see RULE14
                    evt[EVT_WAKE]  = 1'b1;
                end
            end
            default:
            begin
                st_nxt.state = ST_IDLE;
            end
        endcase

        if (takeInt)
        begin
            stFlags[FLAG_MASK_BIT] = st_r.iMask;
            st_nxt.stk       = {stFlags, regsIn.acc, regsIn.idxLo, regsIn.pc[15:8], regsIn.pc[7:0]};
            st_nxt.sp        = spIn;
            st_nxt.iMask     = 1'b1; // see RULE6 RULE15
            st_nxt.coreHold  = 1'b1;
            st_nxt.coreClkEn = 1'b1;
            st_nxt.sysClkEn  = 1'b1;
            st_nxt.step      = 3'h0;
            st_nxt.state     = ST_PUSH;
            if (st_r.trapPend)
            begin
                st_nxt.code = CODE_TRAP; // see RULE12
            end
            else
            begin
                // only the winner is acknowledged, the rest stay latched
                st_nxt.code    = reqCode + CODE_REQ0; // see RULE9 RULE15
                st_nxt.intAck  = 1'b1;
                st_nxt.ackCode = reqCode;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // register slave, one wait state on every access

        if (apbHit)
        begin
            st_nxt.apb.pready = 1'b1;
            st_nxt.apb.prdata = 32'h0000_0000;
            unique case (apbReq.paddr)
                OFS_CTRL:
                begin
                    if (apbReq.pwrite)
                        st_nxt.mon = apbReq.pwdata[CTRL_MON_BIT];
                    st_nxt.apb.prdata[CTRL_MON_BIT] = st_r.mon;
                end
                OFS_STAT:
                begin
                    if (apbReq.pwrite)
                        clr = apbReq.pwdata[EVT_W-1:0];
                    st_nxt.apb.prdata[EVT_W-1:0] = st_r.sts;
                end
                OFS_MASK:
                begin
                    if (apbReq.pwrite)
                        st_nxt.msk = apbReq.pwdata[EVT_W-1:0];
                    st_nxt.apb.prdata[EVT_W-1:0] = st_r.msk;
                end
                OFS_INFO:
                begin
                    st_nxt.apb.prdata = {16'h0000, st_r.iMask, st_r.code, 1'b0, st_r.state};
                end
                default:
                begin
                    st_nxt.apb.pslverr = 1'b1;
                end
            endcase
        end

        // a new event beats a simultaneous write-one-to-clear
        st_nxt.sts    = (st_r.sts & ~clr) | evt;
        st_nxt.irqOut = |(st_nxt.sts & st_nxt.msk);
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r           <= '0;
            st_r.state     <= ST_IDLE;
            st_r.iMask     <= RST_MASK_I; // see RULE7
            st_r.sp        <= RST_SP;
            st_r.coreClkEn <= 1'b1;
            st_r.sysClkEn  <= 1'b1;
            st_r.mon       <= RST_MON;
            st_r.msk       <= RST_EVT_MASK;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign memOut      = st_r.mem;
    assign regsOut     = st_r.regs;
    assign spOut       = st_r.sp;
    assign vecLoad     = st_r.vecLoad;
    assign restoreLoad = st_r.restoreLoad;
    assign coreHold    = st_r.coreHold;
    assign coreClkEn   = st_r.coreClkEn;
    assign sysClkEn    = st_r.sysClkEn;
    assign maskBit     = st_r.iMask;
    assign intAck      = st_r.intAck;
    assign ackCode     = st_r.ackCode;
    assign apbRsp      = st_r.apb;
    assign irqOut      = st_r.irqOut;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence entryTaken;
        st_r.state == ST_IDLE ##1 st_r.state == ST_PUSH;
    endsequence

    sequence lastVecByte;
        st_r.state == ST_VECL && st_r.mem.req && memAck;
    endsequence

    boundary_take_a: assert property ( // see RULE1
        st_r.state == ST_IDLE && coreCtl.instrBoundary && st_r.trapPend |=> st_r.state == ST_PUSH && st_r.coreHold)
        else $error("pending trap not taken at boundary");
    entry_mask_a: assert property (entryTaken |-> st_r.iMask) // see RULE6
        else $error("mask not set on entry");
    trap_code_a: assert property ( // see RULE12
        st_r.state == ST_IDLE && coreCtl.instrBoundary && st_r.trapPend |=> st_r.code == CODE_TRAP && !st_r.intAck)
        else $error("trap lost priority");
    mid_instr_a: assert property ( // see RULE10
        $rose(st_r.coreHold) |-> $past(coreCtl.instrBoundary || coreCtl.trapReturn || st_r.state != ST_IDLE))
        else $error("entry began mid instruction");
    push_count_a: assert property ( // see RULE2
        st_r.state == ST_PUSH && st_r.mem.req && memAck && st_r.step == 3'h4 |=> st_r.state == ST_VECH)
        else $error("wrong number of stacked bytes");
    sp_down_a: assert property ( // see RULE18
        st_r.state == ST_PUSH && st_r.mem.req && memAck |=> st_r.sp == $past(st_r.sp) - 16'h0001)
        else $error("stack pointer not decremented");
    sp_up_a: assert property ( // see RULE18
        st_r.state == ST_PULL && st_r.mem.req && memAck |=> st_r.sp == $past(st_r.sp) + 16'h0001)
        else $error("stack pointer not incremented");
    vec_addr_a: assert property ( // see RULE8
        st_r.state == ST_VECH && st_r.mem.req |-> st_r.mem.addr[7:0] == VEC_LO_TOP - {st_r.code, 1'b0})
        else $error("vector address wrong");
    vec_load_a: assert property (lastVecByte |=> st_r.vecLoad && st_r.regs.pc[7:0] == $past(memRdata)) // see RULE3
        else $error("vector not loaded");
    mask_restore_a: assert property ( // see RULE16
        st_r.state == ST_PULL && st_r.mem.req && memAck && st_r.step == 3'h0
        |=> st_r.iMask == $past(memRdata[FLAG_MASK_BIT]))
        else $error("mask not restored from stacked flags");
    mask_clear_a: assert property ( // see RULE7
        $fell(st_r.iMask) |-> $past(coreCtl.maskClear || coreCtl.flagsXfer || st_r.state == ST_PULL))
        else $error("mask cleared by illegal source");
    return_done_a: assert property ( // see RULE4
        st_r.state == ST_PULL && st_r.mem.req && memAck && st_r.step == 3'h4 |=> st_r.restoreLoad ##1 !st_r.restoreLoad)
        else $error("return did not complete");
    wait_wake_a: assert property ( // see RULE13
        st_r.state == ST_WAIT && reqAny && !st_r.iMask |=> st_r.state == ST_PUSH && st_r.coreClkEn)
        else $error("wait wake failed");
    stop_clk_a: assert property (st_r.state == ST_STOP |-> !st_r.sysClkEn && !st_r.coreClkEn) // see RULE14
        else $error("clocks run in stop");
    single_ack_a: assert property ( // see RULE15
        st_r.intAck |-> st_r.ackCode + CODE_REQ0 == st_r.code ##1 !st_r.intAck [*2])
        else $error("more than winner acknowledged");
    req_gate_a: assert property ( // see RULE5
        st_r.state == ST_IDLE && st_r.iMask && !st_r.trapPend |=> st_r.state != ST_PUSH)
        else $error("request taken while masked");
    code_range_a: assert property (st_r.intAck |-> st_r.code >= CODE_REQ0) // see RULE9
        else $error("request code out of range");

endmodule
`default_nettype wire

//--- dv/ciee_siu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ciee_siu_model
    import ciee_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    input  wire logic [NUM_SRC-1:0] raise,
    input  wire logic               intAck,
    input  wire logic [6:0]         ackCode,
    output logic      [NUM_SRC-1:0] irqReq
);
    logic [NUM_SRC-1:0] pend_r;
    logic [NUM_SRC-1:0] done;

    // only the acknowledged winner drops; the rest stay latched
    assign done = intAck ? NUM_SRC'(1) << ackCode : '0;
    assign irqReq = pend_r;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            pend_r <= '0;
        else
            pend_r <= (pend_r | raise) & ~done;
    end
endmodule
`default_nettype wire

//--- dv/cpu_interrupt_entry_exit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end
module cpu_interrupt_entry_exit_tb;
    import ciee_pkg::*;
    typedef struct packed {logic [6:0] idx; logic [15:0] va;} ciee_row_s;
    localparam logic [8:0] BND = 9'h100, TFE = 9'h080, TRT = 9'h040, MCL = 9'h020, WTQ = 9'h002, STQ = 9'h001;
    logic           sys_clk, rstn = 1'b0, memAck = 1'b0, err;
    logic           vecLoad, restoreLoad, coreHold, coreClkEn, sysClkEn, maskBit, intAck, irqOut;
    ciee_core_ctl_s ctl = '0;
    ciee_regs_s     regs = '0, regsOut;
    ciee_apb_req_s  apbReq = '0;
    ciee_apb_rsp_s  apbRsp;
    ciee_mem_s      memOut;
    logic [15:0]    spIn = 16'h00FF, spOut;
    logic [125:0]   raise = '0, irqReq;
    logic [7:0]     memRdata = 8'h00;
    logic [7:0]     mem [0:65535];
    logic [6:0]     ackCode;
    logic [31:0]    rd;
    int             fails = 0, check_count = 0;
    ciee_row_s      rows [3] = '{'{7'h00, 16'hFFFA}, '{7'h05, 16'hFFF0}, '{7'h7D, 16'hFF00}};

    ciee_core_intr dut (.sys_clk(sys_clk), .rstn(rstn), .coreCtl(ctl), .regsIn(regs), .spIn(spIn),
        .irqReq(irqReq), .memRdata(memRdata), .memAck(memAck), .apbReq(apbReq), .memOut(memOut),
        .regsOut(regsOut), .spOut(spOut), .vecLoad(vecLoad), .restoreLoad(restoreLoad),
        .coreHold(coreHold), .coreClkEn(coreClkEn), .sysClkEn(sysClkEn), .maskBit(maskBit),
        .intAck(intAck), .ackCode(ackCode), .apbRsp(apbRsp), .irqOut(irqOut));
    ciee_siu_model siu (.sys_clk(sys_clk), .rstn(rstn), .raise(raise), .intAck(intAck),
        .ackCode(ackCode), .irqReq(irqReq));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // memory answers one cycle after each request
    always @(posedge sys_clk)
    begin
        memAck <= memOut.req & ~memAck;
        if (memOut.req & ~memAck)
        begin
            memRdata <= mem[memOut.addr];
            if (memOut.wr)
                mem[memOut.addr] <= memOut.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic pulse(input logic [8:0] c);
        @(posedge sys_clk);
        ctl <= ciee_core_ctl_s'(c);
        @(posedge sys_clk);
        ctl <= '0;
    endtask

    task automatic setReq(input logic [125:0] r);
        @(posedge sys_clk);
        raise <= r;
        @(posedge sys_clk);
        raise <= '0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic waitFor(input logic ret);
        for (int i = 0; i < 300; i++)
        begin
            @(posedge sys_clk);
            if ((ret ? restoreLoad : vecLoad) === 1'b1)
                return;
        end
        fails++;
        test_done();
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        for (int i = 0; i < 20; i++)
        begin
            @(posedge sys_clk);
            if (apbRsp.pready === 1'b1)
            begin
                rd = apbRsp.prdata;
                err = apbRsp.pslverr;
                apbReq <= '0;
                return;
            end
        end
        fails++;
        test_done();
    endtask

    // c of zero: a wake from a low-power mode, no boundary needed
    task automatic enter(input logic [15:0] va, input logic [8:0] c);
        if (c != 9'h000)
            pulse(c);
        waitFor(1'b0);
        `CHK("pc", {pat(va), pat(va + 16'h0001)}, regsOut.pc)
        `CHK("sp", 16'h00FA, spOut)
        `CHK("stack", {regs.pc[7:0], regs.pc[15:8], regs.idxLo, regs.acc, regs.flags}, {mem[255], mem[254], mem[253], mem[252], mem[251]})
        `CHK("mask", 1'b1, maskBit)
    endtask

    task automatic leave;
        spIn <= 16'h00FA;
        pulse(TRT);
        waitFor(1'b1);
        `CHK("regs", regs, regsOut)
        `CHK("spRet", 16'h00FF, spOut)
        spIn <= 16'h00FF;
        @(posedge sys_clk);
        `CHK("unmask", 1'b0, maskBit)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 65536; i++)
            mem[i] = pat(16'(i));
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        `CHK("rstMask", 1'b1, maskBit)
        `CHK("rstOut", 20'h00FFC, {spOut, coreClkEn, sysClkEn, irqOut, coreHold})
        setReq(126'h1);
        pulse(BND);
        repeat (4) @(posedge sys_clk);
        `CHK("masked", 1'b0, coreHold)
        foreach (rows[i])
        begin
            regs <= '{8'hA0, 8'h3C, 8'h62, 16'h1234 + 16'(i)};
            setReq(126'h1 << rows[i].idx);
            pulse(MCL);
            repeat (3) @(posedge sys_clk);
            `CHK("clr", 2'b00, {maskBit, coreHold})
            enter(rows[i].va, BND);
            leave();
        end
        setReq(126'h88);
        enter(16'hFFF4, BND);
        leave();
        enter(16'hFFEC, BND);
        leave();
        setReq(126'h2);
        pulse(TFE);
        enter(16'hFFFC, BND);
        leave();
        enter(16'hFFF8, BND);
        leave();
        pulse(WTQ);
        @(posedge sys_clk);
        `CHK("wait", 2'b01, {coreClkEn, sysClkEn})
        setReq(126'h10);
        enter(16'hFFF2, 9'h000);
        `CHK("wake", 1'b1, coreClkEn)
        leave();
        pulse(STQ);
        @(posedge sys_clk);
        `CHK("stop", 2'b00, {coreClkEn, sysClkEn})
        setReq(126'h20);
        enter(16'hFFF0, 9'h000);
        leave();
        // status now holds entry, return and wake events
        apb(1'b1, OFS_MASK, 32'h7);
        repeat (2) @(posedge sys_clk);
        `CHK("irq", 1'b1, irqOut)
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK("stat", 32'h7, rd)
        apb(1'b1, OFS_STAT, 32'h7);
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK("w1c", 33'h0, {irqOut, rd})
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 1'b1, err)
        pulse(9'h010);
        @(posedge sys_clk);
        `CHK("maskSet", 1'b1, maskBit)
        pulse(9'h008);
        @(posedge sys_clk);
        `CHK("xfer", 1'b0, maskBit)
        apb(1'b1, OFS_CTRL, 32'h1);
        setReq(126'h1);
        enter(16'hFEFA, BND);
        leave();
        apb(1'b0, OFS_INFO, 32'h0);
        `CHK("info", {16'h0000, 1'b0, CODE_REQ0, 8'h01}, rd)
        rstn <= 1'b0;
        @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        `CHK("rstMid", 18'h201FE, {maskBit, spOut, coreHold})
        test_done();
    end
endmodule
`default_nettype wire
